// ---- mcu_ports_params.svh ----
// offsets, field positions and reset values of the parallel port block
`ifndef MCU_PORTS_PARAMS_SVH
`define MCU_PORTS_PARAMS_SVH

// ************************************************************
// register offsets
// ************************************************************
`define OFS_PORT0_OUTPUT_LATCH 6'h00
`define OFS_PORT1_OUTPUT_LATCH 6'h01
`define OFS_PORT2_OUTPUT_LATCH 6'h02
`define OFS_PORT3_OUTPUT_LATCH 6'h03
`define OFS_PORT1_DIRECTION    6'h09
`define OFS_PORT3_DIRECTION    6'h0a
`define OFS_PORT0_OUTPUT_TYPE  6'h0b
`define OFS_PORT0_PIN_LEVELS   6'h0c
`define OFS_PORT2_PIN_LEVELS   6'h0d
`define OFS_CONVERTER_CTRL_ONE 6'h0e
`define OFS_EXT_IRQ_CTRL       6'h37

// ************************************************************
// field positions
// ************************************************************
`define BIT_ANALOG_DISABLE     4
`define BIT_IRQ_ZERO_PIN_SEL   6
`define BIT_IRQ_ONE_EDGE       1

// ************************************************************
// reset values
// ************************************************************
`define RST_PORT0_OUTPUT_LATCH 8'hff
`define RST_PORT0_OUTPUT_TYPE  8'h00
`define RST_PORT1_OUTPUT_LATCH 3'h0
`define RST_PORT1_DIRECTION    3'h0
`define RST_PORT2_OUTPUT_LATCH 3'h7
`define RST_PORT3_OUTPUT_LATCH 8'h00
`define RST_PORT3_DIRECTION    8'h00
`define RST_CONVERTER_CTRL_ONE 8'h10
`define RST_EXT_IRQ_CTRL       8'h00

`endif

// ---- mcu_ports_pkg.sv ----
// types shared by the parallel port block
package mcu_ports_pkg;

  // one register bus request, taken in the first state of a cycle
  typedef struct packed {
    logic [5:0] addr;
    logic       rd;
    logic       wr;
    logic [7:0] wdata;
  } sfr_req_s;

  // pin drive bundle of one port
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } pin_drive_s;

endpackage

// ---- pin_sync.sv ----
// two-stage pin synchroniser with edge pulses on the synchronised level
`timescale 1ns/10ps
module pin_sync #(
  parameter int WIDTH = 8
) (
  input  wire logic             sys_clk_i,
  input  wire logic             arst_n_i,
  input  wire logic [WIDTH-1:0] pin_i,
  output logic      [WIDTH-1:0] level_o,
  output logic      [WIDTH-1:0] rise_o,
  output logic      [WIDTH-1:0] fall_o
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  logic [2:0]       primed;

  // ************************************************************
  // synchroniser
  // ************************************************************
  // stage1 is read only by stage2, edges come from stage2 vs stage3
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
      primed <= 3'h0;
    end else begin
      stage1 <= pin_i;
      stage2 <= stage1;
      stage3 <= stage2;
      primed <= {primed[1:0], 1'b1};
    end
  end

  // edges held off until stage3 holds a real pin sample, so a pin
  // idling high gives no false rise after reset
  assign level_o = stage2;
  assign rise_o  = stage2 & ~stage3 & {WIDTH{primed[2]}};
  assign fall_o  = ~stage2 & stage3 & {WIDTH{primed[2]}};

endmodule

// ---- mcu_ports.sv ----
// four parallel i/o ports behind the special function register bus
`timescale 1ns/10ps
`include "mcu_ports_params.svh"

module mcu_ports
  import mcu_ports_pkg::*;
(
  input  wire logic       sys_clk_i,
  input  wire logic       arst_n_i,
  input  wire sfr_req_s   sfr_req_i,
  output logic [7:0]      sfr_rdata_o,
  output logic            sfr_rvalid_o,
  input  wire logic       stop_mode_i,
  input  wire logic       dual_clock_i,
  input  wire logic [7:0] port0_pin_i,
  output logic [7:0]      port0_pin_o,
  output logic [7:0]      port0_pin_oe_o,
  input  wire logic [2:0] port1_pin_i,
  output logic [2:0]      port1_pin_o,
  output logic [2:0]      port1_pin_oe_o,
  input  wire logic [2:0] port2_pin_i,
  output logic [2:0]      port2_pin_o,
  output logic [2:0]      port2_pin_oe_o,
  input  wire logic [7:0] port3_pin_i,
  output logic [7:0]      port3_pin_o,
  output logic [7:0]      port3_pin_oe_o,
  output logic [7:0]      analog_select_o,
  output logic            irq_zero_event_o,
  output logic            irq_one_event_o,
  output logic            port2_bit0_fall_o
);

  // ************************************************************
  // register state
  // ************************************************************
  logic [7:0] port0_output_latch;
  logic [7:0] port0_output_type;
  logic [2:0] port1_output_latch;
  logic [2:0] port1_direction;
  logic [2:0] port2_output_latch;
  logic [7:0] port3_output_latch;
  logic [7:0] port3_direction;
  logic [7:0] converter_control_one;
  logic [7:0] ext_irq_ctrl;
  logic       wr_pending;
  logic [5:0] wr_addr;
  logic [7:0] wr_data;

  logic [7:0] next_port0_output_latch;
  logic [7:0] next_port0_output_type;
  logic [2:0] next_port1_output_latch;
  logic [2:0] next_port1_direction;
  logic [2:0] next_port2_output_latch;
  logic [7:0] next_port3_output_latch;
  logic [7:0] next_port3_direction;
  logic [7:0] next_converter_control_one;
  logic [7:0] next_ext_irq_ctrl;
  logic       next_wr_pending;
  logic [5:0] next_wr_addr;
  logic [7:0] next_wr_data;

  // synchronised pin views
  logic [7:0] p0_level;
  logic [2:0] p1_level;
  logic [2:0] p1_rise;
  logic [2:0] p1_fall;
  logic [2:0] p2_level;
  logic [2:0] p2_fall;
  logic [7:0] p3_level;

  // derived controls
  logic       analog_disable;
  logic       irq_zero_pin_select;
  logic       irq_one_falling;
  logic [7:0] analog_sel;
  logic [7:0] next_analog_sel;

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  pin_sync #(.WIDTH(8)) u_sync_p0 (
    .sys_clk_i (sys_clk_i), .arst_n_i (arst_n_i), .pin_i (port0_pin_i),
    .level_o   (p0_level),  .rise_o   (),         .fall_o ()
  );

  pin_sync #(.WIDTH(3)) u_sync_p1 (
    .sys_clk_i (sys_clk_i), .arst_n_i (arst_n_i), .pin_i (port1_pin_i),
    .level_o   (p1_level),  .rise_o   (p1_rise),  .fall_o (p1_fall)
  );

  pin_sync #(.WIDTH(3)) u_sync_p2 (
    .sys_clk_i (sys_clk_i), .arst_n_i (arst_n_i), .pin_i (port2_pin_i),
    .level_o   (p2_level),  .rise_o   (),         .fall_o (p2_fall)
  );

  pin_sync #(.WIDTH(8)) u_sync_p3 (
    .sys_clk_i (sys_clk_i), .arst_n_i (arst_n_i), .pin_i (port3_pin_i),
    .level_o   (p3_level),  .rise_o   (),         .fall_o ()
  );

  assign analog_disable      = converter_control_one[`BIT_ANALOG_DISABLE];
  assign irq_zero_pin_select = ext_irq_ctrl[`BIT_IRQ_ZERO_PIN_SEL];
  assign irq_one_falling     = ext_irq_ctrl[`BIT_IRQ_ONE_EDGE];

  // ************************************************************
  // register writes
  // ************************************************************
  // request taken in the first state, stored, applied one edge later
  always_comb begin
    next_port0_output_latch    = port0_output_latch;
    next_port0_output_type     = port0_output_type;
    next_port1_output_latch    = port1_output_latch;
    next_port1_direction       = port1_direction;
    next_port2_output_latch    = port2_output_latch;
    next_port3_output_latch    = port3_output_latch;
    next_port3_direction       = port3_direction;
    next_converter_control_one = converter_control_one;
    next_ext_irq_ctrl          = ext_irq_ctrl;
    next_wr_pending            = sfr_req_i.wr;
    next_wr_addr               = sfr_req_i.wr ? sfr_req_i.addr : wr_addr;
    next_wr_data               = sfr_req_i.wr ? sfr_req_i.wdata : wr_data;
    if (wr_pending) begin
      unique case (wr_addr)
        `OFS_PORT0_OUTPUT_LATCH: next_port0_output_latch = wr_data;
        `OFS_PORT1_OUTPUT_LATCH: next_port1_output_latch = wr_data[2:0];
        `OFS_PORT2_OUTPUT_LATCH: next_port2_output_latch = wr_data[2:0];
        `OFS_PORT3_OUTPUT_LATCH: next_port3_output_latch = wr_data;
        `OFS_PORT1_DIRECTION:    next_port1_direction    = wr_data[2:0];
        `OFS_PORT3_DIRECTION:    next_port3_direction    = wr_data;
        `OFS_PORT0_OUTPUT_TYPE:  next_port0_output_type  = wr_data;
        `OFS_CONVERTER_CTRL_ONE: next_converter_control_one = wr_data;
        `OFS_EXT_IRQ_CTRL:       next_ext_irq_ctrl       = wr_data;
        default: ; // read-only and foreign offsets ignore writes
      endcase
    end
  end

  // reset values put every pin in a safe, non-driving state
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      port0_output_latch    <= `RST_PORT0_OUTPUT_LATCH;
      port0_output_type     <= `RST_PORT0_OUTPUT_TYPE;
      port1_output_latch    <= `RST_PORT1_OUTPUT_LATCH;
      port1_direction       <= `RST_PORT1_DIRECTION;
      port2_output_latch    <= `RST_PORT2_OUTPUT_LATCH;
      port3_output_latch    <= `RST_PORT3_OUTPUT_LATCH;
      port3_direction       <= `RST_PORT3_DIRECTION;
      converter_control_one <= `RST_CONVERTER_CTRL_ONE;
      ext_irq_ctrl          <= `RST_EXT_IRQ_CTRL;
      wr_pending            <= 1'b0;
      wr_addr               <= 6'h00;
      wr_data               <= 8'h00;
    end else begin
      port0_output_latch    <= next_port0_output_latch;
      port0_output_type     <= next_port0_output_type;
      port1_output_latch    <= next_port1_output_latch;
      port1_direction       <= next_port1_direction;
      port2_output_latch    <= next_port2_output_latch;
      port3_output_latch    <= next_port3_output_latch;
      port3_direction       <= next_port3_direction;
      converter_control_one <= next_converter_control_one;
      ext_irq_ctrl          <= next_ext_irq_ctrl;
      wr_pending            <= next_wr_pending;
      wr_addr               <= next_wr_addr;
      wr_data               <= next_wr_data;
    end
  end

  // ************************************************************
  // register reads
  // ************************************************************
  logic [7:0] next_rdata;
  logic       next_rvalid;

  // pins are caught two edges before the edge the read is taken
  always_comb begin
    next_rvalid = sfr_req_i.rd;
    next_rdata  = 8'h00;
    if (sfr_req_i.rd) begin
      unique case (sfr_req_i.addr)
        `OFS_PORT0_OUTPUT_LATCH: next_rdata = port0_output_latch;
        `OFS_PORT0_PIN_LEVELS:   next_rdata = p0_level;
        `OFS_PORT0_OUTPUT_TYPE:  next_rdata = port0_output_type;
        // input bits show the pin, output bits the latch
        `OFS_PORT1_OUTPUT_LATCH: next_rdata = {5'h00, (port1_direction & port1_output_latch)
                                   | (~port1_direction & p1_level)};
        `OFS_PORT1_DIRECTION:    next_rdata = {5'h00, port1_direction};
        // upper bits carry no meaning, returned as zero
        `OFS_PORT2_OUTPUT_LATCH: next_rdata = {5'h00, port2_output_latch};
        `OFS_PORT2_PIN_LEVELS:   next_rdata = {5'h00, p2_level};
        // analog or output bits return latch, the rest the live level
        `OFS_PORT3_OUTPUT_LATCH: next_rdata = ((analog_sel | port3_direction)
                                   & port3_output_latch)
                                   | (~(analog_sel | port3_direction) & p3_level);
        `OFS_PORT3_DIRECTION:    next_rdata = port3_direction;
        `OFS_CONVERTER_CTRL_ONE: next_rdata = converter_control_one;
        `OFS_EXT_IRQ_CTRL:       next_rdata = ext_irq_ctrl;
        default:                 next_rdata = 8'h00; // unmapped reads as zero
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sfr_rdata_o  <= 8'h00;
      sfr_rvalid_o <= 1'b0;
    end else begin
      sfr_rdata_o  <= next_rdata;
      sfr_rvalid_o <= next_rvalid;
    end
  end

  // ************************************************************
  // pin drivers
  // ************************************************************
  // drive computed from next register values so pins move with the latch
  pin_drive_s next_p0;
  pin_drive_s next_p3;
  logic [2:0] next_p1_out;
  logic [2:0] next_p1_oe;
  logic [2:0] next_p2_out;
  logic [2:0] next_p2_oe;

  always_comb begin
    // analog selection decoded from the channel select field
    next_analog_sel = 8'h00;
    if (!next_converter_control_one[`BIT_ANALOG_DISABLE]) begin
      next_analog_sel[next_converter_control_one[2:0]] = 1'b1;
    end
    // port 0: push pull drives always, open drain only pulls low
    next_p0.out = next_port0_output_latch & next_port0_output_type;
    next_p0.oe  = next_port0_output_type | ~next_port0_output_latch;
    // port 1: bitwise direction, bit 0 released when used as interrupt
    next_p1_out = next_port1_output_latch;
    next_p1_oe  = next_port1_direction;
    if (next_ext_irq_ctrl[`BIT_IRQ_ZERO_PIN_SEL]) begin
      next_p1_oe[0] = 1'b0;
    end
    // port 2: open drain, latch one releases the pin
    next_p2_out = 3'h0;
    next_p2_oe  = ~next_port2_output_latch;
    if (dual_clock_i) begin
      next_p2_oe[2:1] = 2'b00;
    end
    if (stop_mode_i) begin
      next_p2_oe[0] = 1'b0;
    end
    // port 3: direction drives, analog pins never driven
    next_p3.out = next_port3_output_latch;
    next_p3.oe  = next_port3_direction & ~next_analog_sel;
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      port0_pin_o     <= 8'h00;
      port0_pin_oe_o  <= 8'h00;
      port1_pin_o     <= 3'h0;
      port1_pin_oe_o  <= 3'h0;
      port2_pin_o     <= 3'h0;
      port2_pin_oe_o  <= 3'h0;
      port3_pin_o     <= 8'h00;
      port3_pin_oe_o  <= 8'h00;
      analog_sel      <= 8'h00;
    end else begin
      port0_pin_o     <= next_p0.out;
      port0_pin_oe_o  <= next_p0.oe;
      port1_pin_o     <= next_p1_out;
      port1_pin_oe_o  <= next_p1_oe;
      port2_pin_o     <= next_p2_out;
      port2_pin_oe_o  <= next_p2_oe;
      port3_pin_o     <= next_p3.out;
      port3_pin_oe_o  <= next_p3.oe;
      analog_sel      <= next_analog_sel;
    end
  end

  assign analog_select_o = analog_sel;

  // ************************************************************
  // interrupt edge events
  // ************************************************************
  // the block only reports edges; the latches live with the controller
  logic next_irq0;
  logic next_irq1;
  logic next_p2f;

  always_comb begin
    // interrupt zero only while the pin select is set
    next_irq0 = irq_zero_pin_select & p1_fall[0];
    // driven as output, any own transition counts
    if (port1_direction[1]) begin
      next_irq1 = p1_rise[1] | p1_fall[1];
    end else begin
      next_irq1 = irq_one_falling ? p1_fall[1] : p1_rise[1];
    end
    // pin level watched, so a self-driven fall counts too
    next_p2f = p2_fall[0];
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      irq_zero_event_o  <= 1'b0;
      irq_one_event_o   <= 1'b0;
      port2_bit0_fall_o <= 1'b0;
    end else begin
      irq_zero_event_o  <= next_irq0;
      irq_one_event_o   <= next_irq1;
      port2_bit0_fall_o <= next_p2f;
    end
  end

endmodule

// ---- ports_props.sv ----
// concurrent checks on the parallel port block ports
`timescale 1ns/10ps
module ports_props
  import mcu_ports_pkg::*;
(
  input wire logic       sys_clk_i,
  input wire logic       arst_n_i,
  input wire sfr_req_s   sfr_req_i,
  input wire logic [7:0] sfr_rdata_o,
  input wire logic       sfr_rvalid_o,
  input wire logic       stop_mode_i,
  input wire logic       dual_clock_i,
  input wire logic [7:0] port0_pin_i,
  input wire logic [2:0] port1_pin_i,
  input wire logic [2:0] port1_pin_oe_o,
  input wire logic [2:0] port2_pin_i,
  input wire logic [2:0] port2_pin_oe_o,
  input wire logic [7:0] port3_pin_o,
  input wire logic [7:0] port3_pin_oe_o,
  input wire logic [7:0] analog_select_o,
  input wire logic       irq_zero_event_o,
  input wire logic       irq_one_event_o,
  input wire logic       port2_bit0_fall_o
);
  // ****************
  // properties
  // ****************
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!arst_n_i);

  // one answer per read, one cycle later
  a_read_answer: assert property (sfr_rvalid_o == $past(sfr_req_i.rd))
    else $error("read answer not one cycle after request");
  // pins held still around the request are what comes back
  a_pin_sample: assert property (sfr_req_i.rd && sfr_req_i.addr == 6'h0c
    && $past(arst_n_i, 4) && $stable(port0_pin_i) && port0_pin_i == $past(port0_pin_i, 2)
    && port0_pin_i == $past(port0_pin_i, 3) |=> sfr_rdata_o == $past(port0_pin_i))
    else $error("pin level read wrong");
  a_write_lands: assert property (sfr_req_i.wr && sfr_req_i.addr == 6'h03
    |-> ##2 port3_pin_o == $past(sfr_req_i.wdata, 2)) else $error("port 3 write late");
  a_analog_no_drive: assert property ((analog_select_o & port3_pin_oe_o) == 8'h00)
    else $error("analog pin driven");
  a_stop_float: assert property (stop_mode_i |=> !port2_pin_oe_o[0])
    else $error("stop pin driven in stop");
  a_dual_release: assert property (dual_clock_i |=> port2_pin_oe_o[2:1] == 2'b00)
    else $error("resonator pins driven");
  a_fall_pulse: assert property ($fell(port2_pin_i[0]) |-> ##[2:4] port2_bit0_fall_o)
    else $error("port 2 bit 0 fall missed");
  a_irq_one_out: assert property (port1_pin_oe_o[1] && $changed(port1_pin_i[1])
    |-> ##[2:4] irq_one_event_o) else $error("output edge missed");
  a_irq_zero_gate: assert property (irq_zero_event_o |-> !port1_pin_oe_o[0])
    else $error("irq zero while pin is port");

  // main scenarios reached
  c_read: cover property (sfr_rvalid_o);
  c_fall: cover property (port2_bit0_fall_o);
  c_one: cover property (irq_one_event_o);
  c_zero: cover property (irq_zero_event_o);
endmodule

bind mcu_ports ports_props u_props (
  .sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .sfr_req_i(sfr_req_i),
  .sfr_rdata_o(sfr_rdata_o), .sfr_rvalid_o(sfr_rvalid_o), .stop_mode_i(stop_mode_i),
  .dual_clock_i(dual_clock_i), .port0_pin_i(port0_pin_i), .port1_pin_i(port1_pin_i),
  .port1_pin_oe_o(port1_pin_oe_o), .port2_pin_i(port2_pin_i),
  .port2_pin_oe_o(port2_pin_oe_o), .port3_pin_o(port3_pin_o),
  .port3_pin_oe_o(port3_pin_oe_o), .analog_select_o(analog_select_o),
  .irq_zero_event_o(irq_zero_event_o), .irq_one_event_o(irq_one_event_o),
  .port2_bit0_fall_o(port2_bit0_fall_o));

// ---- pad_bank.sv ----
// board side of one port: pads shared by the block and outside sources
`timescale 1ns/10ps
module pad_bank
  import mcu_ports_pkg::*;
(
  input  wire pin_drive_s drv_i,
  input  wire logic [7:0] ext_i,
  output logic [7:0]      pin_o
);
  // block drive wins where enabled; a released pad shows the outside source,
  // so open drain with latch one reads whatever the board puts there
  assign pin_o = (drv_i.oe & drv_i.out) | (~drv_i.oe & ext_i);
endmodule

// ---- tb_top.sv ----
// self-checking bench for the parallel port block
`timescale 1ns/10ps
module tb_top
  import mcu_ports_pkg::*;
;
  typedef struct packed {logic w; logic [5:0] a; logic [7:0] d;} row_s;
  logic       sys_clk_i;
  logic       arst_n_i   = 1'b0;
  sfr_req_s   sfr_req    = '0;
  logic       stop_mode  = 1'b0;
  logic       dual_clock = 1'b0;
  logic [7:0] ext0 = 8'h3c, ext1 = 8'h05, ext2 = 8'h05, ext3 = 8'ha5;
  logic [7:0] rdata, analog_sel, p0_o, p0_oe, p3_o, p3_oe, pin0, pin1, pin2, pin3;
  logic [2:0] p1_o, p1_oe, p2_o, p2_oe;
  logic       rvalid, irq0, irq1, fall2;
  logic [7:0] zero_cnt = 8'h00, one_cnt = 8'h00, fall_cnt = 8'h00, base, q;
  int         error_cnt = 0, total_checks = 0;
  // reads carry the expected value in d
  row_s rows [30] = '{
    '{1'b0, 6'h00, 8'hff}, '{1'b0, 6'h0b, 8'h00},
    '{1'b0, 6'h0c, 8'h3c},
    '{1'b0, 6'h01, 8'h05}, '{1'b0, 6'h09, 8'h00},
    '{1'b0, 6'h02, 8'h07},
    '{1'b0, 6'h0d, 8'h05},
    '{1'b0, 6'h03, 8'ha5}, '{1'b0, 6'h0a, 8'h00}, '{1'b0, 6'h0e, 8'h10},
    '{1'b0, 6'h37, 8'h00},
    '{1'b1, 6'h0b, 8'hff}, '{1'b1, 6'h00, 8'h96},
    '{1'b0, 6'h00, 8'h96}, '{1'b0, 6'h0c, 8'h96},
    '{1'b1, 6'h0b, 8'h0f}, '{1'b0, 6'h0c, 8'h16},
    '{1'b1, 6'h00, 8'hff}, '{1'b1, 6'h0b, 8'h00}, '{1'b0, 6'h0c, 8'h3c},
    '{1'b1, 6'h09, 8'h06}, '{1'b1, 6'h01, 8'h03}, '{1'b0, 6'h01, 8'h03},
    '{1'b1, 6'h0a, 8'h0f}, '{1'b1, 6'h03, 8'hc3}, '{1'b0, 6'h03, 8'ha3},
    '{1'b1, 6'h0e, 8'h05}, '{1'b0, 6'h03, 8'h83},
    '{1'b1, 6'h0c, 8'h00}, '{1'b0, 6'h0c, 8'h3c}};

  mcu_ports dut (
    .sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .sfr_req_i(sfr_req),
    .sfr_rdata_o(rdata), .sfr_rvalid_o(rvalid), .stop_mode_i(stop_mode),
    .dual_clock_i(dual_clock), .port0_pin_i(pin0), .port0_pin_o(p0_o),
    .port0_pin_oe_o(p0_oe), .port1_pin_i(pin1[2:0]), .port1_pin_o(p1_o),
    .port1_pin_oe_o(p1_oe), .port2_pin_i(pin2[2:0]), .port2_pin_o(p2_o),
    .port2_pin_oe_o(p2_oe), .port3_pin_i(pin3), .port3_pin_o(p3_o),
    .port3_pin_oe_o(p3_oe), .analog_select_o(analog_sel), .irq_zero_event_o(irq0),
    .irq_one_event_o(irq1), .port2_bit0_fall_o(fall2));
  pad_bank u_pad0 (.drv_i({p0_o, p0_oe}), .ext_i(ext0), .pin_o(pin0));
  pad_bank u_pad1 (.drv_i({5'h0, p1_o, 5'h0, p1_oe}), .ext_i(ext1), .pin_o(pin1));
  pad_bank u_pad2 (.drv_i({5'h0, p2_o, 5'h0, p2_oe}), .ext_i(ext2), .pin_o(pin2));
  pad_bank u_pad3 (.drv_i({p3_o, p3_oe}), .ext_i(ext3), .pin_o(pin3));

  // ****************
  // clock, pulse counters, tasks
  // ****************
  initial begin
    sys_clk_i = 1'b0;
    forever #4 sys_clk_i = ~sys_clk_i;
  end
  // pulses last one cycle, so count them rather than poll
  always @(posedge sys_clk_i) begin
    zero_cnt <= zero_cnt + {7'h0, irq0};
    one_cnt  <= one_cnt + {7'h0, irq1};
    fall_cnt <= fall_cnt + {7'h0, fall2};
  end
  task automatic chk(input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask
  // three edges after the take: landed and back through the pin synchroniser
  task automatic wr_t(input logic [5:0] a, input logic [7:0] d);
    sfr_req <= {a, 1'b0, 1'b1, d};
    @(posedge sys_clk_i);
    sfr_req <= '0;
    repeat (3) @(posedge sys_clk_i);
  endtask
  task automatic rd_t(input logic [5:0] a, output logic [7:0] d);
    sfr_req <= {a, 1'b1, 1'b0, 8'h00};
    @(posedge sys_clk_i);
    sfr_req <= '0;
    #1 d = rdata;
    chk(8'h01, {7'h0, rvalid});
    @(posedge sys_clk_i);
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    #60000;
    error_cnt++;
    wrap_up();
  end

  // ****************
  // tests
  // ****************
  initial begin
    repeat (8) @(posedge sys_clk_i);
    arst_n_i <= 1'b1;
    repeat (4) @(posedge sys_clk_i);
    foreach (rows[i]) begin
      if (rows[i].w) wr_t(rows[i].a, rows[i].d);
      else begin
        rd_t(rows[i].a, q);
        chk(rows[i].d, q);
      end
    end
    $display("test table done");
    wr_t(6'h0e, 8'h01);
    chk(8'h02, analog_sel);
    chk(8'h0d, p3_oe);
    chk(8'hc3, p3_o);
    wr_t(6'h03, 8'hff);
    chk(8'h0d, p3_oe);
    $display("test analog done");
    base = fall_cnt;
    wr_t(6'h02, 8'h06);
    repeat (3) @(posedge sys_clk_i);
    chk(8'h01, {5'h0, p2_oe});
    chk(8'h00, {5'h0, p2_o});
    chk(8'h01, fall_cnt - base);
    stop_mode <= 1'b1;
    repeat (2) @(posedge sys_clk_i);
    chk(8'h00, {5'h0, p2_oe});
    stop_mode <= 1'b0;
    dual_clock <= 1'b1;
    wr_t(6'h02, 8'h00);
    chk(8'h01, {5'h0, p2_oe});
    dual_clock <= 1'b0;
    repeat (2) @(posedge sys_clk_i);
    chk(8'h07, {5'h0, p2_oe});
    $display("test port 2 done");
    base = one_cnt;
    wr_t(6'h01, 8'h01);
    wr_t(6'h01, 8'h03);
    repeat (3) @(posedge sys_clk_i);
    chk(8'h02, one_cnt - base);
    chk(8'h03, {5'h0, p1_o});
    wr_t(6'h09, 8'h07);
    chk(8'h07, {5'h0, p1_oe});
    wr_t(6'h37, 8'h40);
    chk(8'h06, {5'h0, p1_oe});
    base = zero_cnt;
    ext1 <= 8'h04;
    repeat (5) @(posedge sys_clk_i);
    chk(8'h01, zero_cnt - base);
    // bit 1 back to input, falling edge selected: only the fall counts
    wr_t(6'h09, 8'h01);
    wr_t(6'h37, 8'h42);
    base = one_cnt;
    ext1 <= 8'h06;
    repeat (5) @(posedge sys_clk_i);
    ext1 <= 8'h04;
    repeat (5) @(posedge sys_clk_i);
    chk(8'h01, one_cnt - base);
    $display("test port 1 done");
    // second reset in mid-run must restore defaults
    arst_n_i <= 1'b0;
    repeat (2) @(posedge sys_clk_i);
    arst_n_i <= 1'b1;
    @(posedge sys_clk_i);
    rd_t(6'h0e, q);
    chk(8'h10, q);
    chk(8'h00, p0_oe);
    chk(8'h00, p0_o);
    chk(8'h00, {5'h0, p1_o});
    $display("test reset done");
    wrap_up();
  end
endmodule
